// ### src/tls_consts.svh
// offsets, field positions and limits of the target list store
`ifndef TLS_CONSTS_SVH
`define TLS_CONSTS_SVH
`define TLS_OFF_CTRL 12'h000
`define TLS_OFF_HDR 12'h004
`define TLS_OFF_COUNT 12'h008
`define TLS_OFF_MOD_ID 12'h00C
`define TLS_OFF_ENTRY 12'h010
`define TLS_OFF_COORD 12'h014
`define TLS_OFF_STATUS 12'h018
`define TLS_OFF_IRQ_STAT 12'h01C
`define TLS_OFF_IRQ_MASK 12'h020
`define TLS_OFF_AXIS_CFG 12'h024
`define TLS_OFF_SYS_NUM 12'h028
`define TLS_OFF_SYS_ID 12'h02C
`define TLS_OFF_WR_LO 12'h030
`define TLS_OFF_WR_HI 12'h034
`define TLS_OFF_ZSR 12'h038
`define TLS_OFF_DIFFS 12'h03C
`define TLS_OFF_ADAPT 12'h040
`define TLS_OFF_AX_COUNT 12'h044
`define TLS_OFF_AX_LIST 12'h048
`define TLS_TYPE_CODE 8'h5A
`define TLS_ROT_LIM_NARROW 32'h05F5E100
`define TLS_ROT_LIM_WIDE 32'h3B9ACA00
`define TLS_DIFF_MAX 16'h7FFF
`define TLS_ADAPT_MAX 32'h000F4240
`define TLS_IRQ_DONE 0
`define TLS_IRQ_ERR 1
`define TLS_IRQ_PRUNE 2
`define TLS_IRQ_W 3
`endif

// ### src/tls_pkg.sv
// types shared by the target list store
package tls_pkg;
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_XFER = 3'b001,
        CMD_DEL = 3'b010,
        CMD_MD_ENTER = 3'b011,
        CMD_MD_DELETE = 3'b100,
        CMD_FUNC_CHANGE = 3'b101
    } cmd_t;

    typedef enum logic [3:0] {
        ERR_NONE = 4'h0,
        ERR_TYPE = 4'h1,
        ERR_FUNC = 4'h2,
        ERR_EXISTS = 4'h3,
        ERR_ID = 4'h4,
        ERR_STATE = 4'h5,
        ERR_LISTNUM = 4'h6,
        ERR_RANGE = 4'h7,
        ERR_BUSY = 4'h8,
        ERR_AXIS = 4'h9,
        ERR_MDATA = 4'hA
    } err_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_COPY = 2'b10,
        ST_RECHECK = 2'b11
    } state_t;

    // one target entry: own set number, speed identifier, coordinate
    typedef struct packed {
        logic [7:0] set_num;
        logic speed;
        logic signed [31:0] coord;
    } entry_t;

    // header of a list being handed over
    typedef struct packed {
        logic [7:0] type_code;
        logic [7:0] module_num;
        logic [7:0] list_num;
        logic [1:0] axis;
    } hdr_t;

    // per-axis configuration written by software
    typedef struct packed {
        logic [2:0] positioning;
        logic [2:0] completed;
        logic [2:0] rotary;
        logic [2:0] wide_range;
    } axis_cfg_t;
endpackage

// ### src/target_list_store.sv
// target list store: checks, stores, deletes and rechecks per-axis target lists
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "tls_consts.svh"

module target_list_store #(
    parameter int DEPTH = 256
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq
);
    initial begin
        if (DEPTH < 256 || DEPTH > 256) begin
            $error("DEPTH must be 256 to hold counts up to 255");
        end
    end

    localparam int AW = $clog2(DEPTH);

    // list storage, one region per axis, plus staging for a list in transfer
    tls_pkg::entry_t store_mem [3*DEPTH];
    tls_pkg::entry_t stage_mem [DEPTH];

    // registers
    tls_pkg::hdr_t hdr;
    logic [7:0] stage_count;
    logic [31:0] hdr_mod_id;
    logic [7:0] entry_idx;
    logic [7:0] entry_set;
    logic entry_speed;
    tls_pkg::axis_cfg_t axis_cfg;
    logic [7:0] sys_num;
    logic [31:0] sys_id;
    logic signed [31:0] wr_lo;
    logic signed [31:0] wr_hi;
    logic [31:0] zsr;
    logic [15:0] diff_chg;
    logic [15:0] diff_cut;
    logic [31:0] adapt;
    logic [7:0] count [3];
    logic [`TLS_IRQ_W-1:0] irq_stat;
    logic [`TLS_IRQ_W-1:0] irq_mask;
    tls_pkg::err_t last_err;
    tls_pkg::state_t state;
    logic [1:0] act_axis;
    logic [7:0] rd_idx;
    logic [7:0] wr_idx;
    logic stage_bad;

    // bus decode
    logic setup_ph;
    logic wr_en;
    logic mapped;
    logic busy;
    logic [2:0] ev_set;
    logic [31:0] next_prdata;

    assign setup_ph = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign busy = (state != tls_pkg::ST_IDLE);

    // rule 10 limit check of one coordinate for an axis
    function automatic logic target_ok(input logic signed [31:0] c, input logic [1:0] ax);
        logic signed [33:0] lo;
        logic signed [33:0] hi;
        logic signed [33:0] lim;
        lo = 34'(wr_lo) - 34'(signed'({1'b0, zsr}));
        hi = 34'(wr_hi) + 34'(signed'({1'b0, zsr}));
        lim = axis_cfg.wide_range[ax] ? 34'(`TLS_ROT_LIM_WIDE) : 34'(`TLS_ROT_LIM_NARROW);
        if (axis_cfg.rotary[ax]) begin
            target_ok = (34'(c) <= lim) && (34'(c) >= -lim);
        end else begin
            target_ok = (34'(c) >= lo) && (34'(c) <= hi);
        end
    endfunction

    // rule 9 range of the machine data differences and adaption value
    function automatic logic mdata_ok();
        mdata_ok = (diff_chg <= `TLS_DIFF_MAX) && (diff_cut <= `TLS_DIFF_MAX)
            && (adapt <= `TLS_ADAPT_MAX) && (wr_lo <= wr_hi);
    endfunction

    // address to byte offset match, shared by read and write paths
    function automatic logic is_mapped(input logic [11:0] a);
        unique case (a)
            `TLS_OFF_CTRL, `TLS_OFF_HDR, `TLS_OFF_COUNT, `TLS_OFF_MOD_ID,
            `TLS_OFF_ENTRY, `TLS_OFF_COORD, `TLS_OFF_STATUS, `TLS_OFF_IRQ_STAT,
            `TLS_OFF_IRQ_MASK, `TLS_OFF_AXIS_CFG, `TLS_OFF_SYS_NUM, `TLS_OFF_SYS_ID,
            `TLS_OFF_WR_LO, `TLS_OFF_WR_HI, `TLS_OFF_ZSR, `TLS_OFF_DIFFS,
            `TLS_OFF_ADAPT, `TLS_OFF_AX_COUNT, `TLS_OFF_AX_LIST: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    assign mapped = is_mapped(paddr);
    assign pslverr = psel && penable && !mapped;

    // list number shown per axis
    function automatic logic [7:0] list_num_of(input logic [1:0] ax);
        list_num_of = (count[ax] == 8'h00) ? 8'h00 : {6'h00, ax} + 8'h01;
    endfunction

    // software configuration and header registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hdr <= '0;
            stage_count <= 8'h00;
            hdr_mod_id <= 32'h0000_0000;
            entry_idx <= 8'h00;
            entry_set <= 8'h00;
            entry_speed <= 1'b0;
            axis_cfg <= '0;
            sys_num <= 8'h00;
            sys_id <= 32'h0000_0000;
            wr_lo <= 32'sh0000_0000;
            wr_hi <= 32'sh0000_0000;
            zsr <= 32'h0000_0000;
            diff_chg <= 16'h0000;
            diff_cut <= 16'h0000;
            adapt <= 32'h0000_0000;
            irq_mask <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                `TLS_OFF_HDR: hdr <= tls_pkg::hdr_t'(pwdata[25:0]);
                `TLS_OFF_COUNT: stage_count <= pwdata[7:0];
                `TLS_OFF_MOD_ID: hdr_mod_id <= pwdata;
                `TLS_OFF_ENTRY: begin
                    entry_idx <= pwdata[7:0];
                    entry_set <= pwdata[15:8];
                    entry_speed <= pwdata[16];
                end
                `TLS_OFF_AXIS_CFG: axis_cfg <= tls_pkg::axis_cfg_t'(pwdata[11:0]);
                `TLS_OFF_SYS_NUM: sys_num <= pwdata[7:0];
                `TLS_OFF_SYS_ID: sys_id <= pwdata;
                `TLS_OFF_WR_LO: wr_lo <= pwdata;
                `TLS_OFF_WR_HI: wr_hi <= pwdata;
                `TLS_OFF_ZSR: zsr <= pwdata;
                `TLS_OFF_DIFFS: begin
                    diff_chg <= pwdata[15:0];
                    diff_cut <= pwdata[31:16];
                end
                `TLS_OFF_ADAPT: adapt <= pwdata;
                `TLS_OFF_IRQ_MASK: irq_mask <= pwdata[`TLS_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // staging of entries: a coordinate write completes the entry record
    always_ff @(posedge core_clk) begin
        if (wr_en && paddr == `TLS_OFF_COORD && !busy) begin
            stage_mem[entry_idx[AW-1:0]] <= '{entry_set, entry_speed, pwdata};
        end
    end

    // command sequencer: checks, commit, delete and recheck
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= tls_pkg::ST_IDLE;
            act_axis <= 2'b00;
            rd_idx <= 8'h00;
            wr_idx <= 8'h00;
            stage_bad <= 1'b0;
            last_err <= tls_pkg::ERR_NONE;
            count[0] <= 8'h00;
            count[1] <= 8'h00;
            count[2] <= 8'h00;
            ev_set <= '0;
        end else begin
            ev_set <= '0;
            unique case (state)
                tls_pkg::ST_IDLE: begin
                    if (wr_en && paddr == `TLS_OFF_CTRL) begin
                        act_axis <= pwdata[9:8];
                        rd_idx <= 8'h00;
                        wr_idx <= 8'h00;
                        stage_bad <= 1'b0;
                        last_err <= tls_pkg::ERR_NONE;
                        if (pwdata[9:8] == 2'b11 && pwdata[2:0] != 3'b100) begin
                            last_err <= tls_pkg::ERR_AXIS;
                            ev_set[`TLS_IRQ_ERR] <= 1'b1;
                        end else begin
                            unique case (tls_pkg::cmd_t'(pwdata[2:0]))
                                tls_pkg::CMD_XFER: begin
                                    act_axis <= hdr.axis - 2'b01;
                                    if (hdr.type_code != `TLS_TYPE_CODE) begin
                                        last_err <= tls_pkg::ERR_TYPE;
                                    end else if (hdr.axis == 2'b00) begin
                                        last_err <= tls_pkg::ERR_AXIS;
                                    end else if (!axis_cfg.positioning[hdr.axis - 2'b01]) begin
                                        last_err <= tls_pkg::ERR_FUNC;
                                    end else if (count[hdr.axis - 2'b01] != 8'h00) begin
                                        last_err <= tls_pkg::ERR_EXISTS;
                                    end else if (hdr_mod_id != sys_id
                                            || hdr.module_num != sys_num) begin
                                        last_err <= tls_pkg::ERR_ID;
                                    end else if (!axis_cfg.completed[hdr.axis - 2'b01]) begin
                                        last_err <= tls_pkg::ERR_STATE;
                                    end else if (hdr.list_num != {6'h00, hdr.axis}) begin
                                        last_err <= tls_pkg::ERR_LISTNUM;
                                    end else if (!mdata_ok()) begin
                                        last_err <= tls_pkg::ERR_MDATA;
                                    end else if (stage_count == 8'h00) begin
                                        ev_set[`TLS_IRQ_DONE] <= 1'b1;
                                    end else begin
                                        state <= tls_pkg::ST_CHECK;
                                    end
                                    if (hdr.type_code != `TLS_TYPE_CODE || hdr.axis == 2'b00
                                            || !axis_cfg.positioning[hdr.axis - 2'b01]
                                            || count[hdr.axis - 2'b01] != 8'h00
                                            || hdr_mod_id != sys_id || hdr.module_num != sys_num
                                            || !axis_cfg.completed[hdr.axis - 2'b01]
                                            || hdr.list_num != {6'h00, hdr.axis}
                                            || !mdata_ok()) begin
                                        ev_set[`TLS_IRQ_ERR] <= 1'b1;
                                    end
                                end
                                tls_pkg::CMD_DEL: begin
                                    if (!axis_cfg.positioning[pwdata[9:8]]) begin
                                        last_err <= tls_pkg::ERR_FUNC;
                                        ev_set[`TLS_IRQ_ERR] <= 1'b1;
                                    end else if (!axis_cfg.completed[pwdata[9:8]]) begin
                                        last_err <= tls_pkg::ERR_STATE;
                                        ev_set[`TLS_IRQ_ERR] <= 1'b1;
                                    end else begin
                                        count[pwdata[9:8]] <= 8'h00;
                                        ev_set[`TLS_IRQ_DONE] <= 1'b1;
                                    end
                                end
                                tls_pkg::CMD_MD_ENTER: begin
                                    if (!mdata_ok()) begin
                                        last_err <= tls_pkg::ERR_MDATA;
                                        ev_set[`TLS_IRQ_ERR] <= 1'b1;
                                    end else if (count[pwdata[9:8]] == 8'h00) begin
                                        ev_set[`TLS_IRQ_DONE] <= 1'b1;
                                    end else begin
                                        state <= tls_pkg::ST_RECHECK;
                                    end
                                end
                                tls_pkg::CMD_MD_DELETE: begin
                                    ev_set[`TLS_IRQ_DONE] <= 1'b1;
                                end
                                tls_pkg::CMD_FUNC_CHANGE: begin
                                    count[pwdata[9:8]] <= 8'h00;
                                    ev_set[`TLS_IRQ_DONE] <= 1'b1;
                                end
                                default: begin
                                    last_err <= tls_pkg::ERR_TYPE;
                                    ev_set[`TLS_IRQ_ERR] <= 1'b1;
                                end
                            endcase
                        end
                    end
                end
                tls_pkg::ST_CHECK: begin
                    if (!target_ok(stage_mem[rd_idx[AW-1:0]].coord, act_axis)) begin
                        stage_bad <= 1'b1;
                    end
                    if (rd_idx == stage_count - 8'h01) begin
                        rd_idx <= 8'h00;
                        if (stage_bad
                                || !target_ok(stage_mem[rd_idx[AW-1:0]].coord, act_axis)) begin
                            state <= tls_pkg::ST_IDLE;
                            last_err <= tls_pkg::ERR_RANGE;
                            ev_set[`TLS_IRQ_ERR] <= 1'b1;
                        end else begin
                            state <= tls_pkg::ST_COPY;
                        end
                    end else begin
                        rd_idx <= rd_idx + 8'h01;
                    end
                end
                tls_pkg::ST_COPY: begin
                    if (rd_idx == stage_count - 8'h01) begin
                        count[act_axis] <= stage_count;
                        state <= tls_pkg::ST_IDLE;
                        ev_set[`TLS_IRQ_DONE] <= 1'b1;
                    end else begin
                        rd_idx <= rd_idx + 8'h01;
                    end
                end
                tls_pkg::ST_RECHECK: begin
                    if (target_ok(store_mem[DEPTH * act_axis + rd_idx].coord, act_axis)) begin
                        wr_idx <= wr_idx + 8'h01;
                    end else begin
                        stage_bad <= 1'b1;
                    end
                    if (rd_idx == count[act_axis] - 8'h01) begin
                        count[act_axis] <= target_ok(store_mem[DEPTH * act_axis + rd_idx].coord,
                            act_axis) ? wr_idx + 8'h01 : wr_idx;
                        state <= tls_pkg::ST_IDLE;
                        ev_set[`TLS_IRQ_DONE] <= 1'b1;
                        ev_set[`TLS_IRQ_PRUNE] <= stage_bad
                            || !target_ok(store_mem[DEPTH * act_axis + rd_idx].coord, act_axis);
                    end else begin
                        rd_idx <= rd_idx + 8'h01;
                    end
                end
                default: state <= tls_pkg::ST_IDLE;
            endcase
            // a command while the interface is not free is refused
            if (busy && wr_en && paddr == `TLS_OFF_CTRL) begin
                last_err <= tls_pkg::ERR_BUSY;
                ev_set[`TLS_IRQ_ERR] <= 1'b1;
            end
        end
    end

    // storage writes: staged copy on commit, compaction on recheck
    always_ff @(posedge core_clk) begin
        if (state == tls_pkg::ST_COPY) begin
            store_mem[DEPTH * act_axis + rd_idx] <= stage_mem[rd_idx[AW-1:0]];
        end else if (state == tls_pkg::ST_RECHECK
                && target_ok(store_mem[DEPTH * act_axis + rd_idx].coord, act_axis)) begin
            store_mem[DEPTH * act_axis + wr_idx] <= store_mem[DEPTH * act_axis + rd_idx];
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_stat <= '0;
        end else if (wr_en && paddr == `TLS_OFF_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~pwdata[`TLS_IRQ_W-1:0]) | ev_set;
        end else begin
            irq_stat <= irq_stat | ev_set;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // read mux, captured in the setup cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            `TLS_OFF_HDR: next_prdata = {6'h00, hdr};
            `TLS_OFF_COUNT: next_prdata = {24'h000000, stage_count};
            `TLS_OFF_MOD_ID: next_prdata = hdr_mod_id;
            `TLS_OFF_ENTRY: next_prdata = {15'h0000, entry_speed, entry_set, entry_idx};
            `TLS_OFF_STATUS: next_prdata = {20'h00000, last_err, 6'h00, state};
            `TLS_OFF_IRQ_STAT: next_prdata = {29'h00000000, irq_stat};
            `TLS_OFF_IRQ_MASK: next_prdata = {29'h00000000, irq_mask};
            `TLS_OFF_AXIS_CFG: next_prdata = {20'h00000, axis_cfg};
            `TLS_OFF_SYS_NUM: next_prdata = {24'h000000, sys_num};
            `TLS_OFF_SYS_ID: next_prdata = sys_id;
            `TLS_OFF_WR_LO: next_prdata = wr_lo;
            `TLS_OFF_WR_HI: next_prdata = wr_hi;
            `TLS_OFF_ZSR: next_prdata = zsr;
            `TLS_OFF_DIFFS: next_prdata = {diff_cut, diff_chg};
            `TLS_OFF_ADAPT: next_prdata = adapt;
            `TLS_OFF_AX_COUNT: next_prdata = {8'h00, count[2], count[1], count[0]};
            `TLS_OFF_AX_LIST: next_prdata = {8'h00, list_num_of(2'd2), list_num_of(2'd1),
                list_num_of(2'd0)};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // read data register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule

// ### testbench/tls_properties.sv
// port assertions for the target list store
`timescale 1ns/1ps
module tls_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic acc;
    logic rd_setup;
    logic mapped;
    // access and read setup phases as plain expressions
    assign acc = psel && penable;
    assign rd_setup = psel && !penable && !pwrite;
    logic mask_seen;
    // word aligned offsets inside the map
    assign mapped = paddr <= 12'h048 && paddr[1:0] == 2'h0;
    // remembers whether the last mask write had any of its 32 data bits set
    always_ff @(posedge core_clk) begin
        if (sys_rst) mask_seen <= 1'b0;
        else if (psel && penable && pwrite && paddr == 12'h020) mask_seen <= |pwdata;
    end
    chk_zero_wait: assert property (acc |-> pready)
        else $error("pready low in an access cycle");
    chk_bad_addr: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without pslverr");
    chk_good_addr: assert property (acc && mapped |-> !pslverr)
        else $error("pslverr on a mapped access");
    chk_bad_read: assert property (rd_setup && !mapped |=> prdata == 32'h0)
        else $error("unmapped read returned data");
    chk_read_hold: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data moved without a read");
    chk_mask_off: assert property (acc && pwrite && paddr == 12'h020 && pwdata == 32'h0
        |=> !irq [*2])
        else $error("irq high with mask cleared");
    chk_irq_masked: assert property (irq |-> mask_seen)
        else $error("irq high with nothing unmasked");
    chk_reset_clean: assert property ($fell(sys_rst) |-> !irq && prdata == 32'h0)
        else $error("outputs not clean after reset");
endmodule
bind target_list_store tls_properties u_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ### testbench/apb_host.sv
// apb host model handing data sets to the target list store
`timescale 1ns/1ps
module apb_host (
    // clock
    input wire logic core_clk,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    // setup, access held until pready, then release with scrambled lines
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the target list store
`timescale 1ns/1ps
`include "tls_consts.svh"
module tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, mask_v;
    logic signed [31:0] co[8];
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'h9566AC3C;
    localparam logic [31:0] ID = 32'h1234ABCD; // arbitrary module id
    always #4 core_clk = ~core_clk;
    target_list_store #(.DEPTH(256)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    apb_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task close_out;
        $display("errors %0d compares %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); host.xfer(1'b1, a, d, q, e); endtask
    task rd(input logic [11:0] a); host.xfer(1'b0, a, 32'h0, q, e); endtask
    // command, wait for a free interface, check error code and interrupt
    task run(input logic [2:0] c, input logic [1:0] ax, input logic [3:0] x);
        wr(`TLS_OFF_CTRL, {22'h0, ax, 5'h0, c});
        do rd(`TLS_OFF_STATUS); while (q[1:0] !== 2'h0);
        chk(q[11:8], x);
        rd(`TLS_OFF_IRQ_STAT);
        chk(q[1:0], (x != 4'h0) ? 2'h2 : 2'h1);
        chk(irq, |(q[1:0] & mask_v[1:0]));
        wr(`TLS_OFF_IRQ_STAT, 32'h7);
        $display("command %0d axis %0d done", c, ax);
    endtask
    task load(input logic [7:0] ty, input logic [1:0] ax, input logic [7:0] ln, input int n,
        input logic [31:0] id);
        wr(`TLS_OFF_HDR, {6'h0, ty, 8'h07, ln, ax});
        wr(`TLS_OFF_COUNT, n);
        wr(`TLS_OFF_MOD_ID, id);
        for (int i = 0; i < n; i++) begin
            wr(`TLS_OFF_ENTRY, {15'h0, i[0], 8'h10 + i[7:0], i[7:0]});
            wr(`TLS_OFF_COORD, co[i]);
        end
    endtask
    // entries surviving a recheck against lo-10 .. hi+10
    function int keep(input int n, input int hi);
        keep = 0;
        for (int i = 0; i < n; i++) if (co[i] <= hi + 10 && co[i] >= -1010) keep++;
    endfunction
    // hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            close_out;
        end
    end
    initial begin
        mask_v = 32'h3;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        wr(`TLS_OFF_AXIS_CFG, 32'hFC0);
        wr(`TLS_OFF_SYS_NUM, 32'h7);
        wr(`TLS_OFF_SYS_ID, ID);
        wr(`TLS_OFF_WR_LO, 32'hFFFFFC18);
        wr(`TLS_OFF_WR_HI, 32'h3E8);
        wr(`TLS_OFF_ZSR, 32'hA);
        wr(`TLS_OFF_IRQ_MASK, mask_v);
        for (int i = 0; i < 8; i++) co[i] = $random(seed) % 1000;
        co[0] = 1010;
        co[1] = 1011;
        load(8'h00, 2'd1, 8'd1, 2, ID); run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_TYPE);
        load(`TLS_TYPE_CODE, 2'd1, 8'd1, 2, ~ID); run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_ID);
        load(`TLS_TYPE_CODE, 2'd1, 8'd1, 2, ID); run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_RANGE);
        co[1] = -1010;
        for (int a = 1; a < 4; a++) for (int l = 1; l < 4; l++) if (a != l) begin
            load(`TLS_TYPE_CODE, a[1:0], l[7:0], 2, ID);
            run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_LISTNUM);
        end
        load(`TLS_TYPE_CODE, 2'd1, 8'd1, 8, ID);
        wr(`TLS_OFF_AXIS_CFG, 32'hDC0); run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_FUNC);
        wr(`TLS_OFF_AXIS_CFG, 32'hF80); run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_STATE);
        wr(`TLS_OFF_AXIS_CFG, 32'hFC0); run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_NONE);
        rd(`TLS_OFF_AX_COUNT); chk(q, 32'h8);
        rd(`TLS_OFF_AX_LIST); chk(q, 32'h1);
        run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_EXISTS);
        run(tls_pkg::CMD_MD_DELETE, 2'd0, tls_pkg::ERR_NONE);
        rd(`TLS_OFF_AX_COUNT); chk(q, 32'h8);
        wr(`TLS_OFF_WR_HI, 32'h0); run(tls_pkg::CMD_MD_ENTER, 2'd0, tls_pkg::ERR_NONE);
        rd(`TLS_OFF_AX_COUNT); chk(q, keep(8, 0));
        mask_v = 32'h0;
        wr(`TLS_OFF_IRQ_MASK, mask_v);
        wr(`TLS_OFF_AXIS_CFG, 32'hF80); run(tls_pkg::CMD_DEL, 2'd0, tls_pkg::ERR_STATE);
        rd(`TLS_OFF_AX_COUNT); chk(q, keep(8, 0));
        mask_v = 32'h3;
        wr(`TLS_OFF_IRQ_MASK, mask_v);
        wr(`TLS_OFF_AXIS_CFG, 32'hFC0); run(tls_pkg::CMD_DEL, 2'd0, tls_pkg::ERR_NONE);
        rd(`TLS_OFF_AX_LIST); chk(q, 32'h0);
        wr(`TLS_OFF_WR_HI, 32'h3E8);
        load(`TLS_TYPE_CODE, 2'd2, 8'd2, 4, ID); run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_NONE);
        rd(`TLS_OFF_AX_COUNT); chk(q, 32'h400);
        rd(`TLS_OFF_AX_LIST); chk(q, 32'h200);
        run(tls_pkg::CMD_FUNC_CHANGE, 2'd1, tls_pkg::ERR_NONE);
        rd(`TLS_OFF_AX_COUNT); chk(q, 32'h0);
        run(tls_pkg::CMD_DEL, 2'd3, tls_pkg::ERR_AXIS);
        wr(`TLS_OFF_DIFFS, 32'h8000);
        run(tls_pkg::CMD_MD_ENTER, 2'd0, tls_pkg::ERR_MDATA);
        wr(`TLS_OFF_DIFFS, 32'h0);
        co[1] = 32'sh05F5E101;
        wr(`TLS_OFF_AXIS_CFG, 32'hFE0); load(`TLS_TYPE_CODE, 2'd3, 8'd3, 2, ID);
        run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_RANGE);
        wr(`TLS_OFF_AXIS_CFG, 32'hFE4);
        run(tls_pkg::CMD_XFER, 2'd0, tls_pkg::ERR_NONE);
        rd(`TLS_OFF_AX_COUNT); chk(q, 32'h20000);
        rd(12'h0FC); chk(q, 32'h0); chk(e, 1'b1);
        close_out;
    end
endmodule
